// >>> include/msc_cfg.svh
`ifndef MSC_CFG_SVH
`define MSC_CFG_SVH
// ********************************************************************
// register map
// ********************************************************************
`define MSC_ADDR_W          8
`define MSC_OFF_CFG_A       8'h84
`define MSC_OFF_CFG_B       8'h86
`define MSC_OFF_STATUS      8'h88
`define MSC_RST_CFG_A       32'h0000_0000
`define MSC_RST_CFG_B       32'h0000_0000
// ********************************************************************
// first register fields
// ********************************************************************
`define MSC_A_REV_PROFILE   0
`define MSC_A_ACTIVE_BRAKE  1
`define MSC_A_RAMPDOWN      2
`define MSC_A_LIMIT_SRC     3
`define MSC_A_REPEAT_LO     4
`define MSC_A_REPEAT_HI     5
`define MSC_A_ADV_LO        6
`define MSC_A_ADV_HI        7
`define MSC_A_RELEASE       8
`define MSC_A_THR_LO        9
`define MSC_A_THR_HI        13
`define MSC_THR_FIRST_RSVD  5'h13
`define MSC_A_WR_MASK       32'h7fff_ffff
// ********************************************************************
// second register fields
// ********************************************************************
`define MSC_B_WR_MASK       32'h7fff_ffff
`define MSC_B_OLLIM_LO      27
`define MSC_B_OLLIM_HI      30
`define MSC_B_ACC1_LO       23
`define MSC_B_ACC1_HI       26
`define MSC_B_ACC2_LO       19
`define MSC_B_ACC2_HI       22
`endif

// >>> include/msc_pkg.sv
package msc_pkg;
   // start-up sequencer state, one-hot
   typedef enum logic [2:0] {
      MSC_IDLE   = 3'b001,
      MSC_DETECT = 3'b010,
      MSC_RUN    = 3'b100
   } msc_state_e;

   typedef struct packed {
      logic [31:0] cfg_a;
      logic [31:0] cfg_b;
      logic [31:0] act_a;
      logic [31:0] act_b;
      msc_state_e  state;
      logic [1:0]  passes;
      logic [31:0] rdata;
   } msc_state_s;
endpackage : msc_pkg

// >>> logic/msc_startup_regs.sv
`timescale 1ns/1ps
`include "msc_cfg.svh"
// Operation
// - threshold codes 13h..1Fh are reserved and never select a valid threshold.
// - bit 8 after position detect: 0 brakes phases, 1 leaves them tristated.
// - bits 7-6 add advance angle 0, 30, 60 or 90 degrees.
// - bits 5-4 run detection one to four times, averaging repeats.
// - bit 3 chooses dedicated open-loop limit (0) or run limit (1).
// - bit 2 set enables torque-current ramp-down after closed-loop handoff.
// - bit 1 set enables active braking by reverse drive while decelerating.
// - bit 0 picks forward (0) or reverse (1) open-loop current and accelerations.
// - all low fields of first register are read-write, resetting to zero.
// - second register sits at offset 86h, resets to zero.
// - second register bit 31 is read-only reserved; other fields read-write.
// - first register bits 13-9 hold the five-bit detect current threshold.
module msc_startup_regs (
   // clock, reset, enable
   input  wire logic        i_clk,
   input  wire logic        i_rst_n,
   input  wire logic        i_ce,
   // register port
   input  wire logic [7:0]  i_addr,
   input  wire logic [31:0] i_wdata,
   input  wire logic        i_wr,
   input  wire logic        i_rd,
   output logic      [31:0] o_rdata,
   // start-up sequencer handshake
   input  wire logic        i_start,
   input  wire logic        i_detect_done,
   input  wire logic        i_handoff,
   input  wire logic        i_stop,
   // configuration in force and sequencer state
   output logic      [4:0]  o_detect_current_threshold,
   output logic             o_threshold_valid,
   output logic             o_release_tristate,
   output logic             o_release_brake,
   output logic      [6:0]  o_advance_angle_deg,
   output logic      [2:0]  o_detect_runs,
   output logic             o_detect_more,
   output logic             o_use_run_limit,
   output logic             o_rampdown_en,
   output logic             o_active_brake_en,
   output logic             o_reverse_profile,
   output logic      [3:0]  o_open_loop_current_limit,
   output logic      [3:0]  o_open_loop_accel_first,
   output logic      [3:0]  o_open_loop_accel_second,
   output logic      [2:0]  o_state
);
   // ****************************************************************
   // state
   // ****************************************************************
   msc_pkg::msc_state_s q;
   msc_pkg::msc_state_s next_q;

   // ****************************************************************
   // next state
   // ****************************************************************
   // register writes land in cfg_*; the sequencer only ever reads the
   // act_* copies, latched at start, so a write mid-sequence is harmless
   always_comb begin
      next_q       = q;
      next_q.rdata = 32'h0000_0000;
      if (i_wr) begin
         unique case (i_addr)
            `MSC_OFF_CFG_A: next_q.cfg_a = i_wdata & `MSC_A_WR_MASK;
            `MSC_OFF_CFG_B: next_q.cfg_b = i_wdata & `MSC_B_WR_MASK;
            default: ;
         endcase
      end
      if (i_rd) begin
         unique case (i_addr)
            `MSC_OFF_CFG_A:  next_q.rdata = q.cfg_a;
            `MSC_OFF_CFG_B:  next_q.rdata = q.cfg_b;
            `MSC_OFF_STATUS: next_q.rdata = {27'h0, q.passes, q.state};
            default:         next_q.rdata = 32'h0000_0000;
         endcase
      end
      unique case (q.state)
         msc_pkg::MSC_IDLE: begin
            if (i_start) begin
               next_q.act_a  = q.cfg_a;
               next_q.act_b  = q.cfg_b;
               next_q.passes = 2'h0;
               next_q.state  = msc_pkg::MSC_DETECT;
            end
         end
         msc_pkg::MSC_DETECT: begin
            // one detect pass per done pulse until the repeat count is met
            if (i_stop) begin
               next_q.state = msc_pkg::MSC_IDLE;
            end else if (i_detect_done) begin
               if (q.passes == q.act_a[`MSC_A_REPEAT_HI:`MSC_A_REPEAT_LO]) begin
                  next_q.state = msc_pkg::MSC_RUN;
               end else begin
                  next_q.passes = q.passes + 2'h1;
               end
            end
         end
         msc_pkg::MSC_RUN: begin
            if (i_stop) begin
               next_q.state = msc_pkg::MSC_IDLE;
            end
         end
         default: next_q.state = msc_pkg::MSC_IDLE;
      endcase
   end

   // ****************************************************************
   // registers
   // ****************************************************************
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         q.cfg_a  <= `MSC_RST_CFG_A;
         q.cfg_b  <= `MSC_RST_CFG_B;
         q.act_a  <= `MSC_RST_CFG_A;
         q.act_b  <= `MSC_RST_CFG_B;
         q.state  <= msc_pkg::MSC_IDLE;
         q.passes <= 2'h0;
         q.rdata  <= 32'h0000_0000;
      end else if (i_ce) begin
         q <= next_q;
      end
   end

   // ****************************************************************
   // outputs
   // ****************************************************************
   logic [4:0] thr;
   assign thr = q.act_a[`MSC_A_THR_HI:`MSC_A_THR_LO];

   assign o_rdata                    = q.rdata;
   assign o_detect_current_threshold = thr;
   // reserved codes flag invalid so the detector never uses them
   assign o_threshold_valid          = (thr < `MSC_THR_FIRST_RSVD);
   // release action only asserted once detection has finished
   assign o_release_tristate = (q.state == msc_pkg::MSC_RUN) && q.act_a[`MSC_A_RELEASE];
   assign o_release_brake    = (q.state == msc_pkg::MSC_RUN) && !q.act_a[`MSC_A_RELEASE];
   // 0/30/60/90 degrees is the code times 30
   assign o_advance_angle_deg = 7'(q.act_a[`MSC_A_ADV_HI:`MSC_A_ADV_LO] * 7'd30);
   assign o_detect_runs       = 3'(q.act_a[`MSC_A_REPEAT_HI:`MSC_A_REPEAT_LO]) + 3'h1;
   assign o_detect_more       = (q.state == msc_pkg::MSC_DETECT);
   assign o_use_run_limit     = q.act_a[`MSC_A_LIMIT_SRC];
   // ramp-down only meaningful once handed to closed loop
   assign o_rampdown_en       = q.act_a[`MSC_A_RAMPDOWN] && i_handoff;
   assign o_active_brake_en   = q.act_a[`MSC_A_ACTIVE_BRAKE];
   assign o_reverse_profile   = q.act_a[`MSC_A_REV_PROFILE];
   assign o_open_loop_current_limit = q.act_b[`MSC_B_OLLIM_HI:`MSC_B_OLLIM_LO];
   assign o_open_loop_accel_first   = q.act_b[`MSC_B_ACC1_HI:`MSC_B_ACC1_LO];
   assign o_open_loop_accel_second  = q.act_b[`MSC_B_ACC2_HI:`MSC_B_ACC2_LO];
   assign o_state                   = q.state;
endmodule : msc_startup_regs

// >>> verif/msc_startup_regs_checker.sv
`timescale 1ns/1ps
// ***
// port checks
// ***
module msc_startup_checker (
   // watched ports
   input  wire logic        i_clk,
   input  wire logic        i_rst_n,
   input  wire logic        i_rd,
   input  wire logic        i_start,
   input  wire logic        i_handoff,
   input  wire logic [31:0] o_rdata,
   input  wire logic [4:0]  o_detect_current_threshold,
   input  wire logic        o_threshold_valid,
   input  wire logic        o_release_tristate,
   input  wire logic        o_release_brake,
   input  wire logic [6:0]  o_advance_angle_deg,
   input  wire logic [2:0]  o_detect_runs,
   input  wire logic        o_rampdown_en,
   input  wire logic [2:0]  o_state
);
   default clocking @(posedge i_clk); endclocking
   default disable iff (!i_rst_n);
   property p_thr; o_threshold_valid == (o_detect_current_threshold < 5'h13); endproperty
   a_thr: assert property (p_thr) else $error("threshold valid flag wrong");
   property p_rel; o_state == 3'b100 && $past(o_state) == 3'b100 |-> o_release_tristate ^ o_release_brake; endproperty
   a_rel: assert property (p_rel) else $error("release mode not one-hot");
   property p_adv; o_advance_angle_deg inside {7'h00, 7'h1e, 7'h3c, 7'h5a}; endproperty
   a_adv: assert property (p_adv) else $error("advance angle off grid");
   property p_runs; o_detect_runs inside {3'h1, 3'h2, 3'h3, 3'h4}; endproperty
   a_runs: assert property (p_runs) else $error("detect runs out of range");
   property p_ramp; o_rampdown_en |-> i_handoff; endproperty
   a_ramp: assert property (p_ramp) else $error("ramp-down before handoff");
   property p_rst; $rose(i_rst_n) |-> o_state == 3'b001 && o_detect_runs == 3'h1 && o_rdata == 32'h0; endproperty
   a_rst: assert property (p_rst) else $error("outputs not at reset value");
   property p_b31; $past(i_rd) |-> !o_rdata[31]; endproperty
   a_b31: assert property (p_b31) else $error("reserved bit reads one");
   property p_hold; o_state == 3'b100 && !i_start |=> $stable(o_advance_angle_deg); endproperty
   a_hold: assert property (p_hold) else $error("config changed mid-sequence");
endmodule : msc_startup_checker
bind msc_startup_regs msc_startup_checker u_chk (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_rd(i_rd),
   .i_start(i_start), .i_handoff(i_handoff), .o_rdata(o_rdata),
   .o_detect_current_threshold(o_detect_current_threshold), .o_threshold_valid(o_threshold_valid),
   .o_release_tristate(o_release_tristate), .o_release_brake(o_release_brake),
   .o_advance_angle_deg(o_advance_angle_deg), .o_detect_runs(o_detect_runs),
   .o_rampdown_en(o_rampdown_en), .o_state(o_state));

// >>> verif/tb_msc_startup_regs.sv
`timescale 1ns/1ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin errors++; $display("ERROR %0t %h %h", $time, a, b); end end
// ***
// bench
// ***
module tb_msc_startup_regs;
   logic        i_clk, i_rst_n, i_ce, i_wr, i_rd, i_start, i_detect_done, i_handoff, i_stop;
   logic [7:0]  i_addr;
   logic [31:0] i_wdata, o_rdata;
   logic [4:0]  o_thr;
   logic [6:0]  o_adv;
   logic [2:0]  o_runs, o_state;
   logic        o_tv, o_tri, o_brk, o_lim, o_ramp, o_abrk, o_rev, o_more;
   logic [3:0]  o_olim, o_acc1, o_acc2;
   int          errors, cmp_count;
   msc_startup_regs DUT (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_ce(i_ce), .i_addr(i_addr), .i_wdata(i_wdata),
      .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_start(i_start), .i_detect_done(i_detect_done),
      .i_handoff(i_handoff), .i_stop(i_stop), .o_detect_current_threshold(o_thr), .o_threshold_valid(o_tv),
      .o_release_tristate(o_tri), .o_release_brake(o_brk), .o_advance_angle_deg(o_adv), .o_detect_runs(o_runs),
      .o_detect_more(o_more), .o_use_run_limit(o_lim), .o_rampdown_en(o_ramp), .o_active_brake_en(o_abrk),
      .o_reverse_profile(o_rev), .o_open_loop_current_limit(o_olim), .o_open_loop_accel_first(o_acc1),
      .o_open_loop_accel_second(o_acc2), .o_state(o_state));
   // 100 mhz clock
   initial begin
      i_clk = 1'b0;
      forever #5 i_clk = ~i_clk;
   end
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge i_clk);
      i_addr <= a;
      i_wdata <= d;
      i_wr <= 1'b1;
      @(posedge i_clk);
      i_wr <= 1'b0;
   endtask : wr
   // read data stands only in the cycle after the strobe
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      @(posedge i_clk);
      i_addr <= a;
      i_rd <= 1'b1;
      @(posedge i_clk);
      i_rd <= 1'b0;
      #1 `CHK(o_rdata, e)
   endtask : rd
   // sel 0 start, 1 pass done, 2 stop
   task automatic pulse(input int sel, input int n);
      repeat (n) begin
         @(posedge i_clk);
         i_start <= sel == 0;
         i_detect_done <= sel == 1;
         i_stop <= sel == 2;
         @(posedge i_clk);
         {i_start, i_detect_done, i_stop} <= 3'b0;
      end
      repeat (2) @(posedge i_clk);
      #1;
   endtask : pulse
   task automatic t_map;
      rd(8'h84, 32'h0);
      rd(8'h86, 32'h0);
      wr(8'h86, 32'hffff_ffff);
      rd(8'h86, 32'h7fff_ffff);
      wr(8'h90, 32'h1234_5678);
      rd(8'h90, 32'h0);
      $display("t_map done");
   endtask : t_map
   // each code per field; thresholds step from last valid into reserved
   task automatic t_fields;
      logic [31:0] v;
      for (int k = 0; k < 4; k++) begin
         v = {18'h0, 5'h12 + 5'(k), k[0], k[1:0], k[1:0], k[0], k[1], k[0], k[1]};
         wr(8'h84, v);
         rd(8'h84, v);
         i_handoff <= k[1];
         pulse(0, 1);
         `CHK(o_thr, 5'h12 + 5'(k))
         `CHK(o_tv, k == 0)
         `CHK(o_adv, 7'(30 * k))
         `CHK(o_runs, 3'(k + 1))
         `CHK(o_lim, k[0])
         `CHK(o_ramp, k[1])
         `CHK(o_abrk, k[0])
         `CHK(o_rev, k[1])
         wr(8'h84, 32'h0);
         pulse(1, k + 1);
         `CHK(o_state, 3'b100)
         `CHK(o_tri, k[0])
         `CHK(o_brk, !k[0])
         `CHK(o_adv, 7'(30 * k))
         pulse(2, 1);
         `CHK(o_state, 3'b001)
      end
      $display("t_fields done");
   endtask : t_fields
   // second register fields, status, abort in detect, enable freeze, reset during detect
   task automatic t_misc;
      wr(8'h86, 32'h4b18_0000);
      wr(8'h84, 32'h0000_0010);
      pulse(0, 1);
      `CHK(o_olim, 4'h9)
      `CHK(o_acc1, 4'h6)
      `CHK(o_acc2, 4'h3)
      `CHK(o_more, 1'b1)
      rd(8'h88, 32'h0000_0002);
      pulse(1, 1);
      rd(8'h88, 32'h0000_000a);
      @(posedge i_clk);
      i_ce <= 1'b0;
      pulse(1, 1);
      `CHK(o_state, 3'b010)
      @(posedge i_clk);
      i_ce <= 1'b1;
      pulse(2, 1);
      `CHK(o_state, 3'b001)
      `CHK(o_more, 1'b0)
      pulse(0, 1);
      @(posedge i_clk);
      i_rst_n <= 1'b0;
      repeat (2) @(posedge i_clk);
      i_rst_n <= 1'b1;
      @(posedge i_clk);
      #1 `CHK(o_state, 3'b001)
      rd(8'h84, 32'h0);
      rd(8'h86, 32'h0);
      $display("t_misc done");
   endtask : t_misc
   task automatic finish_test;
      $display("compares %0d mismatches %0d", cmp_count, errors);
      if (errors == 0 && cmp_count > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : finish_test
   // main sequence
   initial begin
      {i_rst_n, i_wr, i_rd, i_start, i_detect_done, i_handoff, i_stop} = 7'h0;
      i_ce = 1'b1;
      i_addr = 8'h0;
      i_wdata = 32'h0;
      repeat (6) @(posedge i_clk);
      i_rst_n <= 1'b1;
      t_map;
      t_fields;
      t_misc;
      finish_test;
   end
   // watchdog, far beyond the roughly 140 cycles needed
   initial begin
      #50000;
      errors++;
      finish_test;
   end
endmodule : tb_msc_startup_regs
